// ===== adc_seq_pkg.sv
// constants, enumerations and carriers for the conversion-frame sequencer
// assumes the select and serial clock inputs arrive synchronous to i_clk_sys
package adc_seq_pkg;
  localparam int CODE_W = 8;           // converter result width
  localparam int FRAME_BITS = 16;      // bits shifted per complete frame
  localparam int LEAD_ZEROS = 3;       // zero bits ahead of the code
  localparam int TAIL_ZEROS = FRAME_BITS - LEAD_ZEROS - CODE_W;
  localparam int FIFO_DEPTH = 8;       // result buffer depth in words
  localparam int CNT_W = 5;            // width of the edge counters
  localparam logic [CNT_W-1:0] FRAME_PERIODS = 5'h14;   // 20 clocks/frame
  localparam logic [CNT_W-1:0] MODE_HOLD_EDGE = 5'h02;  // 2nd falling edge
  localparam logic [CNT_W-1:0] KEEP_NORMAL_EDGE = 5'h0a; // 10th falling
  localparam logic [CNT_W-1:0] DONE_EDGE = 5'h10;       // 16th falling edge
  localparam logic [CNT_W-1:0] TRACK_RISE_EDGE = 5'h0d; // 13th rising edge

  // power state of the analog core; unknown until a frame has run
  typedef enum logic [1:0] {PWR_UNKNOWN, PWR_NORMAL, PWR_SHUTDOWN} power_e;

  // frame sequencing state
  typedef enum logic [1:0] {FR_IDLE, FR_CONV, FR_WAIT_CS} frame_e;

  // one code from the successive-approximation core
  typedef struct packed {
    logic [CODE_W-1:0] code;
  } code_s;

  // completed conversion as reported to the core side
  typedef struct packed {
    logic [CODE_W-1:0] code;  // code shifted out in this frame
    logic dummy;              // first frame after power-on or shutdown
    logic short_gap;          // frame began under 20 clocks after the last
    logic empty;              // no buffered code was available
  } result_s;
endpackage

// ===== adc_code_fifo.sv
// synchronous fifo carrying converter codes to the serial shifter
// assumes one clock; both sides use valid/ready handshakes
`timescale 1ns/10ps
module adc_code_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer arithmetic wraps naturally only for powers of two
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("adc_code_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic [AW-1:0] wr_ptr;          // next slot to write
  logic [AW-1:0] rd_ptr;          // oldest slot
  logic [AW:0] count;             // words held
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic do_wr;
  logic do_rd;

  // honest flags straight from the fill count
  assign o_wr_ready = (count != (AW+1)'(DEPTH));
  assign o_rd_valid = (count != '0);
  assign o_rd_data = mem[rd_ptr];
  assign do_wr = i_wr_valid & o_wr_ready;
  assign do_rd = i_rd_ready & o_rd_valid;

  // pointer and count update
  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end
endmodule

// ===== adc_serial_conversion_sequencer.sv
// frame sequencer of a serial 8-bit converter: select, serial clock,
// three-state result output, power mode, track and hold timing
// assumes select and serial clock are sampled on i_clk_sys as is
`timescale 1ns/10ps
module adc_serial_conversion_sequencer #(
  parameter int FIFO_DEPTH = adc_seq_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cs_n,                    // select, active low
  input wire logic i_sclk,                    // serial clock, sampled
  input wire adc_seq_pkg::code_s i_code,      // code from the core
  input wire logic i_code_valid,
  output logic o_code_ready,
  output logic o_serial_result_out,           // serial result data
  output logic o_serial_result_oe,            // high while driven
  output logic o_track,                       // high: tracking input
  output adc_seq_pkg::power_e o_power_state,
  output logic o_powering_up,                 // core power-up in progress
  output adc_seq_pkg::result_s o_result,
  output logic o_result_valid                 // one-cycle pulse
);
  localparam int CW = adc_seq_pkg::CNT_W;

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("sequencer: FIFO_DEPTH must be at least 2");
    end
  end

  // sampled previous levels for edge detection
  logic cs_n_q;
  logic sclk_q;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  // frame state
  adc_seq_pkg::frame_e state;
  adc_seq_pkg::frame_e next_state;
  adc_seq_pkg::power_e power;
  adc_seq_pkg::power_e next_power;
  adc_seq_pkg::power_e entry_power;  // mode held before this frame began
  adc_seq_pkg::power_e next_entry_power;
  logic [CW-1:0] fall_cnt;       // falling edges since select fell
  logic [CW-1:0] next_fall_cnt;
  logic [CW-1:0] rise_cnt;       // rising edges since select fell
  logic [CW-1:0] next_rise_cnt;
  logic [CW-1:0] gap_cnt;        // falling edges since last frame start
  logic [CW-1:0] next_gap_cnt;
  logic [adc_seq_pkg::FRAME_BITS-1:0] shifter;
  logic [adc_seq_pkg::FRAME_BITS-1:0] next_shifter;
  logic serial_result_out;
  logic next_serial_result_out;
  logic serial_result_out_oe;
  logic next_serial_result_out_oe;
  logic track;
  logic next_track;
  logic powering;
  logic next_powering;
  adc_seq_pkg::result_s result;
  adc_seq_pkg::result_s next_result;
  logic result_valid;
  logic next_result_valid;

  // fifo drain side
  adc_seq_pkg::code_s head;
  logic head_valid;
  logic head_take;

  assign cs_fall = cs_n_q & ~i_cs_n;
  assign cs_rise = ~cs_n_q & i_cs_n;
  assign sclk_fall = sclk_q & ~i_sclk;
  assign sclk_rise = ~sclk_q & i_sclk;
  // a code is consumed only when a frame starts, so the buffer can fill
  assign head_take = cs_fall && (state == adc_seq_pkg::FR_IDLE);

  adc_code_fifo #(
    .WIDTH($bits(adc_seq_pkg::code_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_wr_data(i_code),
    .i_wr_valid(i_code_valid),
    .o_wr_ready(o_code_ready),
    .o_rd_data(head),
    .o_rd_valid(head_valid),
    .i_rd_ready(head_take)
  );

  // next-state logic of the frame sequencer
  always_comb begin
    next_state = state;
    next_power = power;
    next_entry_power = entry_power;
    next_fall_cnt = fall_cnt;
    next_rise_cnt = rise_cnt;
    next_gap_cnt = gap_cnt;
    next_shifter = shifter;
    next_serial_result_out = serial_result_out;
    next_serial_result_out_oe = serial_result_out_oe;
    next_track = track;
    next_powering = powering;
    next_result = result;
    next_result_valid = 1'b0;
    // free-running period count, saturates at a full frame
    if (sclk_fall && gap_cnt != adc_seq_pkg::FRAME_PERIODS) begin
      next_gap_cnt = gap_cnt + 1'b1;
    end
    case (state)
      adc_seq_pkg::FR_IDLE: begin
        if (cs_fall) begin
          // frame start: enter normal mode and power up if needed
          next_state = adc_seq_pkg::FR_CONV;
          next_power = adc_seq_pkg::PWR_NORMAL;
          // remember the old mode so a noise-short frame can restore it
          next_entry_power = power;
          next_powering = (power != adc_seq_pkg::PWR_NORMAL);
          next_result.dummy = (power != adc_seq_pkg::PWR_NORMAL);
          next_result.short_gap =
            (gap_cnt < adc_seq_pkg::FRAME_PERIODS);
          next_result.empty = ~head_valid;
          next_result.code = head_valid ? head.code : '0;
          next_gap_cnt = '0;
          next_fall_cnt = '0;
          next_rise_cnt = '0;
          next_track = 1'b0;
          next_shifter = {{adc_seq_pkg::LEAD_ZEROS{1'b0}},
                          next_result.code,
                          {adc_seq_pkg::TAIL_ZEROS{1'b0}}};
          next_serial_result_out = 1'b0;
          next_serial_result_out_oe = 1'b1;
        end
      end
      adc_seq_pkg::FR_CONV: begin
        if (cs_rise) begin
          // early select release aborts the word
          next_state = adc_seq_pkg::FR_IDLE;
          next_serial_result_out_oe = 1'b0;
          next_track = 1'b1;
          if (fall_cnt >= adc_seq_pkg::MODE_HOLD_EDGE &&
              fall_cnt < adc_seq_pkg::KEEP_NORMAL_EDGE) begin
            next_power = adc_seq_pkg::PWR_SHUTDOWN;
            next_powering = 1'b0;
          end else if (fall_cnt < adc_seq_pkg::MODE_HOLD_EDGE) begin
            // too short to count: back to the mode held before the frame
            next_power = entry_power;
            next_powering = 1'b0;
          end else begin
            next_power = adc_seq_pkg::PWR_NORMAL;
          end
        end else begin
          if (sclk_rise) begin
            next_rise_cnt = rise_cnt + 1'b1;
            if (rise_cnt + 1'b1 == adc_seq_pkg::TRACK_RISE_EDGE) begin
              next_track = 1'b1;
            end
          end
          if (sclk_fall) begin
            next_fall_cnt = fall_cnt + 1'b1;
            next_shifter = {shifter[adc_seq_pkg::FRAME_BITS-2:0], 1'b0};
            next_serial_result_out = shifter[adc_seq_pkg::FRAME_BITS-2];
            if (fall_cnt + 1'b1 == adc_seq_pkg::DONE_EDGE) begin
              // conversion complete, release the output
              next_serial_result_out_oe = 1'b0;
              next_serial_result_out = 1'b0;
              next_powering = 1'b0;
              next_track = 1'b1;
              next_result_valid = 1'b1;
              next_state = adc_seq_pkg::FR_WAIT_CS;
            end
          end
        end
      end
      adc_seq_pkg::FR_WAIT_CS: begin
        // select idled low after a full word must rise before a new frame
        if (cs_rise) begin
          next_state = adc_seq_pkg::FR_IDLE;
        end
      end
      default: begin
        next_state = adc_seq_pkg::FR_IDLE;
      end
    endcase
  end

  // sequencer registers; power starts unknown
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      state <= adc_seq_pkg::FR_IDLE;
      power <= adc_seq_pkg::PWR_UNKNOWN;
      entry_power <= adc_seq_pkg::PWR_UNKNOWN;
      fall_cnt <= '0;
      rise_cnt <= '0;
      gap_cnt <= adc_seq_pkg::FRAME_PERIODS;
      shifter <= '0;
      serial_result_out <= 1'b0;
      serial_result_out_oe <= 1'b0;
      track <= 1'b1;
      powering <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      cs_n_q <= i_cs_n;
      sclk_q <= i_sclk;
      state <= next_state;
      power <= next_power;
      entry_power <= next_entry_power;
      fall_cnt <= next_fall_cnt;
      rise_cnt <= next_rise_cnt;
      gap_cnt <= next_gap_cnt;
      shifter <= next_shifter;
      serial_result_out <= next_serial_result_out;
      serial_result_out_oe <= next_serial_result_out_oe;
      track <= next_track;
      powering <= next_powering;
      result <= next_result;
      result_valid <= next_result_valid;
    end
  end

  // outputs straight from registers
  assign o_serial_result_out = serial_result_out;
  assign o_serial_result_oe = serial_result_out_oe;
  assign o_track = track;
  assign o_power_state = power;
  assign o_powering_up = powering;
  assign o_result = result;
  assign o_result_valid = result_valid;
endmodule

// ===== adc_seq_monitor.sv
// port checker for the conversion-frame sequencer
// assumes select and serial clock are sampled on i_clk_sys
`timescale 1ns/10ps
module adc_seq_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic o_serial_result_oe,
  input wire logic o_track,
  input wire adc_seq_pkg::power_e o_power_state,
  input wire logic o_powering_up,
  input wire adc_seq_pkg::result_s o_result,
  input wire logic o_result_valid
);
  logic pcs, psc, fr, next_fr;  // last samples, frame open
  logic [4:0] nf, nr, next_nf, next_nr;  // falls and rises in frame
  adc_seq_pkg::power_e pw0, next_pw0;  // mode before the frame
  wire st = pcs & ~i_cs_n;  // frame start
  wire up = fr & ~pcs & i_cs_n;  // select rise inside a frame
  wire fl = fr & ~i_cs_n & psc & ~i_sclk;  // counted fall
  wire rs = fr & ~i_cs_n & ~psc & i_sclk;  // counted rise
  wire last = fl & (nf == 5'h0f);  // sixteenth fall
  // frame tracking: counts move only inside an open frame
  always_comb begin
    next_fr = fr;
    next_nf = nf;
    next_nr = nr;
    next_pw0 = pw0;
    if (st) begin
      next_fr = 1'b1;
      next_nf = 5'h00;
      next_nr = 5'h00;
      next_pw0 = o_power_state;
    end else if (up || last) begin
      next_fr = 1'b0;
    end else begin
      next_nf = nf + 5'(fl);
      next_nr = nr + 5'(rs);
    end
  end
  // registers of the tracker, reset like the design's edge detectors
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pcs <= 1'b1;
      psc <= 1'b0;
      fr <= 1'b0;
      nf <= 5'h00;
      nr <= 5'h00;
      pw0 <= adc_seq_pkg::PWR_UNKNOWN;
    end else begin
      pcs <= i_cs_n;
      psc <= i_sclk;
      fr <= next_fr;
      nf <= next_nf;
      nr <= next_nr;
      pw0 <= next_pw0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  property p_start;
    st |=> o_serial_result_oe && !o_track
      && o_power_state == adc_seq_pkg::PWR_NORMAL;
  endproperty
  a_start: assert property (p_start)
    else $error("frame start outputs wrong");
  property p_hold; fr && !up && nr < 5'h0c |=> !o_track; endproperty
  a_hold: assert property (p_hold)
    else $error("track before rise 13");
  property p_track; rs && nr == 5'h0c |=> o_track; endproperty
  a_track: assert property (p_track)
    else $error("no track at rise 13");
  property p_done;
    last |=> o_result_valid && !o_serial_result_oe && !o_powering_up;
  endproperty
  a_done: assert property (p_done)
    else $error("fall 16 did not complete");
  property p_sd;
    up && nf >= 5'h02 && nf < 5'h0a |=> !o_serial_result_oe
      && o_power_state == adc_seq_pkg::PWR_SHUTDOWN;
  endproperty
  a_sd: assert property (p_sd)
    else $error("no shutdown on early rise");
  property p_keep; up && nf < 5'h02 |=> o_power_state == pw0; endproperty
  a_keep: assert property (p_keep)
    else $error("mode changed on very early rise");
  property p_trunc;
    up && nf >= 5'h0a |=> !o_result_valid && !o_serial_result_oe
      && o_power_state == adc_seq_pkg::PWR_NORMAL;
  endproperty
  a_trunc: assert property (p_trunc)
    else $error("late abort wrong");
  property p_dummy;
    st |=> o_result.dummy == (pw0 != adc_seq_pkg::PWR_NORMAL);
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy flag wrong");
  property p_pwrup;
    st |=> o_powering_up == (pw0 != adc_seq_pkg::PWR_NORMAL);
  endproperty
  a_pwrup: assert property (p_pwrup)
    else $error("power-up flag wrong at frame start");
endmodule
bind adc_serial_conversion_sequencer adc_seq_monitor mon (
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_cs_n(i_cs_n),
  .i_sclk(i_sclk),
  .o_serial_result_oe(o_serial_result_oe),
  .o_track(o_track),
  .o_power_state(o_power_state),
  .o_powering_up(o_powering_up),
  .o_result(o_result),
  .o_result_valid(o_result_valid)
);

// ===== adc_ctl_model.sv
// controller model: drives select and serial clock
// assumes the bench clock; lines change 1 ns after a rising edge
`timescale 1ns/10ps
module adc_ctl_model (
  input wire logic i_clk_sys,
  output logic o_cs_n,
  output logic o_sclk
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
  end
  // one serial clock level, held for two system clocks
  task automatic half(input logic v);
    @(posedge i_clk_sys);
    #1 o_sclk = v;
    @(posedge i_clk_sys);
  endtask
  // frame of n clock periods, select raised, then pad free clocks
  task automatic frame(input int n, input int pad);
    @(posedge i_clk_sys);
    #1 o_cs_n = 1'b0;
    repeat (n) begin
      half(1'b1);
      half(1'b0);
    end
    @(posedge i_clk_sys);
    #1 o_cs_n = 1'b1;
    repeat (pad) begin
      half(1'b1);
      half(1'b0);
    end
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask
endmodule

// ===== adc_serial_conversion_sequencer_tb.sv
// bench for the conversion-frame sequencer with a controller model
// assumes a 50 MHz clock; inputs change 1 ns after rising edges
`timescale 1ns/10ps
module adc_serial_conversion_sequencer_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, sclk, ready, sdo, oe, track, pup, rv, psc;
  logic valid = 1'b0;
  adc_seq_pkg::code_s code = '0;
  adc_seq_pkg::power_e pwr;
  adc_seq_pkg::result_s res;
  int bad_count = 0;
  int cmp_count = 0;
  int rv_cnt = 0;  // completion pulses seen
  logic [15:0] word = '0;  // bits taken off the serial output
  adc_ctl_model ctl (.i_clk_sys(clk), .o_cs_n(cs_n), .o_sclk(sclk));
  adc_serial_conversion_sequencer dut (.i_clk_sys(clk), .i_rstn(rstn),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_code(code), .i_code_valid(valid),
    .o_code_ready(ready), .o_serial_result_out(sdo),
    .o_serial_result_oe(oe), .o_track(track), .o_power_state(pwr),
    .o_powering_up(pup), .o_result(res), .o_result_valid(rv));
  initial forever #10 clk = ~clk;
  // take the shown bit at each serial fall while driven
  always @(posedge clk) begin
    psc <= sclk;
    if (psc === 1'b1 && sclk === 1'b0 && oe === 1'b1)
      word <= {word[14:0], sdo};
    if (rv === 1'b1)
      rv_cnt <= rv_cnt + 1;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // full frame: word, one completion pulse, result flags
  task automatic t_frame(input int pad, input logic [7:0] c,
                         input logic [2:0] f);
    int n0;
    n0 = rv_cnt;
    ctl.frame(16, pad);
    check(word, {3'h0, c, 5'h00});
    check(16'(rv_cnt - n0), 16'h1);
    check(16'(res), 16'({c, f}));
    check(16'({oe, pup, track, pwr}),
          16'({3'b001, adc_seq_pkg::PWR_NORMAL}));
    $display("frame test done");
  endtask
  // aborted frame after n falls: mode, three-state, no completion
  task automatic t_abort(input int n, input adc_seq_pkg::power_e p);
    int n0;
    n0 = rv_cnt;
    ctl.frame(n, 0);
    check(16'({oe, pup, pwr}), 16'(p));
    check(16'(rv_cnt - n0), 16'h0);
    $display("abort test done");
  endtask
  task automatic put(input logic [7:0] c);
    code.code = c;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
  endtask
  // back-to-back writes until refused, then drain with slow frames
  task automatic t_fill;
    valid = 1'b1;
    for (int i = 0; i < 9; i++) begin
      code.code = 8'(128 + i);
      @(posedge clk);
      #1;
    end
    valid = 1'b0;
    check(16'(ready), 16'h0);
    for (int i = 0; i < 8; i++)
      t_frame(4, 8'(128 + i), (i == 0) ? 3'b110 : 3'b000);
    t_frame(4, 8'h00, 3'b001);
    check(16'(ready), 16'h1);
    $display("buffer test done");
  endtask
  // reset in mid-run: buffer emptied, power unknown, next frame dummy
  task automatic t_reset;
    put(8'h3c);
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    check(16'({oe, track, pwr, ready}), 16'h9);
    t_frame(4, 8'h00, 3'b101);
    $display("reset test done");
  endtask
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    check(16'({oe, track, pwr, ready}), 16'h9);
    put(8'h5a);
    t_frame(4, 8'h5a, 3'b100);
    put(8'ha5);
    t_frame(3, 8'ha5, 3'b000);
    t_frame(4, 8'h00, 3'b011);
    t_abort(12, adc_seq_pkg::PWR_NORMAL);
    t_abort(1, adc_seq_pkg::PWR_NORMAL);
    t_abort(5, adc_seq_pkg::PWR_SHUTDOWN);
    t_abort(1, adc_seq_pkg::PWR_SHUTDOWN);
    t_fill;
    t_reset;
    finish_test;
  end
endmodule
